// File: spmc_ctrl.sv
// Mode control and serial result shifter of a 12-bit sampling converter.
// Contract
// - Select rise at falls 2..9 enters shutdown.
// - Early rise aborts conversion, output goes idle.
// - Rise before second fall keeps normal mode.
// - Select fall in shutdown starts power-up.
// - Wake frame ended before tenth fall: shutdown.
// - Powered up after sixteen wake-frame cycles.
// - Mode after power-on is unknown.
// - Analog circuitry off during shutdown.
// - Shift three zeros then twelve bits, MSB first.
// - Select fall samples input, enables output.
// - Output idle after sixteenth fall or select rise.
// - Late rise truncates output, mode stays normal.
`timescale 1ns/100ps
module spmc_ctrl
  import spmc_pkg::*;
(
  // Clock and reset.
  input  wire logic                         clk,
  input  wire logic                         srst,
  // Serial link pins from the host.
  input  wire logic                         conversion_select_n,
  input  wire logic                         serial_bit_clock,
  // Serial result pin, as data and output enable.
  output logic                              serial_result_out,
  output logic                              serial_result_oe,
  // Results from the converter core.
  input  wire logic [spmc_pkg::SAMPLE_W-1:0] conv_data,
  input  wire logic                         conv_valid,
  output logic                              conv_ready,
  // Controls and status towards the analog core.
  output logic                              sample_hold,
  output logic                              analog_power_en,
  output logic                              powered_up,
  output logic                              mode_normal,
  output logic                              result_dummy
);
  import spmc_pkg::*;

  logic [2:0]            cs_sync_reg;    // Select synchroniser and edge stage.
  logic [2:0]            sclk_sync_reg;  // Bit clock synchroniser and edge stage.
  logic                  cs_fall;        // Select went low.
  logic                  cs_rise;        // Select went high.
  logic                  sclk_fall;      // Bit clock fell while selected.
  logic                  in_frame_reg;   // Select is low after a seen fall.
  logic [EDGE_CNT_W-1:0] edge_cnt_reg;   // Bit-clock falls in this frame.
  logic [EDGE_CNT_W-1:0] edge_cnt_next;  // Count after this cycle's fall.
  spmc_mode_e            mode_reg;       // Present operating mode.
  logic [FRAME_BITS-1:0] shift_reg;      // Output word, MSB on the pin.
  logic [SAMPLE_W-1:0]   buf_data;       // Oldest buffered result.
  logic                  buf_valid;      // A result is waiting.
  logic [1:0]            buf_level;      // Words held by the buffer now.
  logic [1:0]            buf_level_next; // Words held after this cycle.
  logic                  core_push;      // Core hands over a word this cycle.
  logic                  core_pop;       // Shifter takes the oldest word.
  logic                  buf_in_ready;   // Buffer can take a result.

  // Only stage 0 feeds stage 1; edges are read from stages 1 and 2.
  always_ff @(posedge clk) begin
    if (srst) begin
      cs_sync_reg   <= 3'h7;
      sclk_sync_reg <= 3'h7;
    end else begin
      cs_sync_reg   <= {cs_sync_reg[1:0], conversion_select_n};
      sclk_sync_reg <= {sclk_sync_reg[1:0], serial_bit_clock};
    end
  end

  assign cs_fall   = cs_sync_reg[2] && !cs_sync_reg[1];
  assign cs_rise   = !cs_sync_reg[2] && cs_sync_reg[1];
  assign sclk_fall = in_frame_reg && sclk_sync_reg[2] && !sclk_sync_reg[1];

  // The counter saturates so that an idle-low select never wraps to a
  // small count and fakes a short frame.
  always_comb begin
    edge_cnt_next = edge_cnt_reg;
    if (sclk_fall && (edge_cnt_reg != EDGE_SAT)) begin
      edge_cnt_next = edge_cnt_reg + 1'b1;
    end
  end

  // Frame tracking and falling-edge count.
  always_ff @(posedge clk) begin
    if (srst) begin
      in_frame_reg <= 1'b0;
      edge_cnt_reg <= '0;
    end else if (cs_fall) begin
      in_frame_reg <= 1'b1;
      edge_cnt_reg <= '0;
    end else if (cs_rise) begin
      in_frame_reg <= 1'b0;
    end else begin
      edge_cnt_reg <= edge_cnt_next;
    end
  end

  // Mode decision: a select fall in shutdown starts waking; the select rise decides from the edge count.
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg <= spmc_mode_e'(RESET_MODE);
    end else if (cs_fall) begin
      if (mode_reg == SPMC_SHUTDOWN) begin
        mode_reg <= SPMC_WAKING;
      end
    end else if (cs_rise) begin
      if (edge_cnt_reg >= EDGE_KEEP) begin
        mode_reg <= SPMC_NORMAL;
      end else if ((edge_cnt_reg < EDGE_MIN) && (mode_reg == SPMC_NORMAL)) begin
        mode_reg <= SPMC_NORMAL;
      end else begin
        mode_reg <= SPMC_SHUTDOWN;
      end
    end
  end

  // Power state; a waking frame is fully powered after its sixteenth cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      analog_power_en <= 1'b0;
      powered_up      <= 1'b0;
      mode_normal     <= 1'b0;
    end else begin
      analog_power_en <= (mode_reg != SPMC_SHUTDOWN);
      mode_normal     <= (mode_reg == SPMC_NORMAL);
      if (mode_reg == SPMC_NORMAL) begin
        powered_up <= 1'b1;
      end else if (mode_reg == SPMC_SHUTDOWN) begin
        powered_up <= 1'b0;
      end else if (edge_cnt_reg >= EDGE_POWER) begin
        powered_up <= 1'b1;
      end
    end
  end

  // Result buffer; the core sees back-pressure through conv_ready.
  spmc_buf #(
    .W (SAMPLE_W),
    .D (BUF_DEPTH)
  ) spmc_buf_i (
    .clk       (clk),
    .srst      (srst),
    .in_data   (conv_data),
    .in_valid  (core_push),
    .in_ready  (buf_in_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (cs_fall)
  );

  // The buffer only takes what the core sees taken, so no word is doubled.
  assign core_push = conv_valid && conv_ready;
  // A select fall pops the oldest word whenever one is held.
  assign core_pop  = buf_valid && cs_fall;

  // Fill level rebuilt from the buffer's flags; with two entries, valid and
  // ready together mean exactly one word is held.
  always_comb begin
    buf_level = 2'h0;
    if (buf_valid) begin
      buf_level = buf_in_ready ? 2'h1 : 2'h2;
    end
    buf_level_next = buf_level + {1'b0, core_push} - {1'b0, core_pop};
  end

  // Ready is a register that predicts room for the next cycle. This keeps
  // the core's handshake free of logic paths, at the price of a small adder.
  always_ff @(posedge clk) begin
    if (srst) begin
      conv_ready <= 1'b0;
    end else begin
      conv_ready <= (buf_level_next < 2'(BUF_DEPTH));
    end
  end

  // Sample strobe and dummy marker, both taken at the select fall.
  always_ff @(posedge clk) begin
    if (srst) begin
      sample_hold  <= 1'b0;
      result_dummy <= 1'b0;
    end else begin
      sample_hold <= cs_fall;
      if (cs_fall) begin
        result_dummy <= (mode_reg == SPMC_SHUTDOWN);
      end
    end
  end

  // Output shifter. The first zero is on the pin from the select fall;
  // each bit-clock fall moves the next bit up. With no buffered result
  // the frame carries zeros rather than a stale word.
  always_ff @(posedge clk) begin
    if (srst) begin
      shift_reg        <= '0;
      serial_result_oe <= 1'b0;
    end else if (cs_fall) begin
      shift_reg        <= {{LEAD_ZEROS{1'b0}},
                           (buf_valid ? buf_data : {SAMPLE_W{1'b0}}),
                           {(FRAME_BITS - LEAD_ZEROS - SAMPLE_W){1'b0}}};
      serial_result_oe <= 1'b1;
    end else if (cs_rise) begin
      serial_result_oe <= 1'b0;
    end else if (sclk_fall) begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], 1'b0};
      if (edge_cnt_next >= EDGE_LAST) begin
        serial_result_oe <= 1'b0;
      end
    end
  end
  assign serial_result_out = shift_reg[FRAME_BITS-1];
endmodule

// File: spmc_pkg.sv
// Constants and types shared by the serial converter mode-control block.
package spmc_pkg;
  // Width of one conversion result.
  localparam int unsigned SAMPLE_W    = 12;
  // Number of leading zero bits shifted ahead of the result.
  localparam int unsigned LEAD_ZEROS  = 3;
  // Bits in one output frame, leading zeros and padding included.
  localparam int unsigned FRAME_BITS  = 16;
  // Width of the falling-edge counter; it saturates at its top value.
  localparam int unsigned EDGE_CNT_W  = 5;
  // Fewest bit-clock falls that let a select rise leave normal mode.
  localparam logic [4:0]  EDGE_MIN    = 5'h02;
  // Bit-clock falls needed, select still low, to stay in normal mode.
  localparam logic [4:0]  EDGE_KEEP   = 5'h0A;
  // Bit-clock falls after which the output returns to high impedance.
  localparam logic [4:0]  EDGE_LAST   = 5'h10;
  // Bit-clock cycles in a wake-up frame after which power-up is complete.
  localparam logic [4:0]  EDGE_POWER  = 5'h10;
  // Top value of the saturating edge counter.
  localparam logic [4:0]  EDGE_SAT    = 5'h1F;
  // Depth of the result buffer between the converter core and the shifter.
  localparam int unsigned BUF_DEPTH   = 2;
  // Mode after reset; the real part may wake in either mode.
  localparam logic [1:0]  RESET_MODE  = 2'h0;

  // Operating modes of the converter.
  typedef enum logic [1:0] {
    SPMC_SHUTDOWN = 2'b00,
    SPMC_WAKING   = 2'b01,
    SPMC_NORMAL   = 2'b10
  } spmc_mode_e;
endpackage

// File: spmc_buf.sv
// Two-entry result buffer with valid and ready on both sides.
`timescale 1ns/100ps
module spmc_buf #(
  parameter int unsigned W = 12,
  parameter int unsigned D = 2
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         srst,
  // Filling side.
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Draining side.
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0]  mem_reg [D];   // Storage, addressed by pointer.
  logic [AW-1:0] wr_ptr_reg;    // Next slot to write.
  logic [AW-1:0] rd_ptr_reg;    // Oldest slot.
  logic [AW:0]   count_reg;     // Entries held.
  logic          push;          // Word accepted this cycle.
  logic          pop;           // Word drained this cycle.

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count_reg != D[AW:0]);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      // Simultaneous push and pop leave the count unchanged.
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// File: spmc_ctrl_assertions.sv
// Concurrent checks on the pins of the mode-control block.
`timescale 1ns/100ps
module spmc_ctrl_assertions (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Link pins.
  input wire logic conversion_select_n,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  // Status towards the core.
  input wire logic sample_hold,
  input wire logic analog_power_en,
  input wire logic powered_up,
  input wire logic mode_normal,
  input wire logic result_dummy
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  hold_on_fall_a: assert property ($fell(conversion_select_n) |-> ##[2:5] sample_hold)
    else $error("no sample pulse after select fall");
  pulse_once_a: assert property (sample_hold |=> !sample_hold)
    else $error("sample pulse too long");
  first_zero_a: assert property (sample_hold |-> serial_result_oe && !serial_result_out)
    else $error("frame does not open with a driven zero");
  oe_release_a: assert property ($rose(conversion_select_n) |-> ##[1:6] !serial_result_oe)
    else $error("output still driven after select rise");
  idle_quiet_a: assert property (conversion_select_n [*6] |-> !serial_result_oe)
    else $error("output driven while not selected");
  wake_start_a: assert property ($rose(analog_power_en) |-> $past(sample_hold) && result_dummy)
    else $error("power-up not tied to select fall");
  normal_power_a: assert property (mode_normal |-> powered_up && analog_power_en)
    else $error("normal mode without power");
  mode_at_rise_a: assert property ($changed(mode_normal) |-> !serial_result_oe)
    else $error("mode changed inside a frame");
  dummy_mark_a: assert property ($changed(result_dummy) |-> sample_hold)
    else $error("dummy flag moved outside select fall");
  power_off_a: assert property ($fell(analog_power_en) |-> !mode_normal)
    else $error("power dropped while normal");
endmodule
bind spmc_ctrl spmc_ctrl_assertions spmc_ctrl_assertions_i (.clk(clk), .srst(srst),
  .conversion_select_n(conversion_select_n), .serial_result_out(serial_result_out),
  .serial_result_oe(serial_result_oe), .sample_hold(sample_hold),
  .analog_power_en(analog_power_en), .powered_up(powered_up),
  .mode_normal(mode_normal), .result_dummy(result_dummy));

// File: spmc_host.sv
// Host model that drives the serial link and reads back each frame.
`timescale 1ns/100ps
module spmc_host (
  // Link pins driven by the host.
  output logic     conversion_select_n,
  output logic     serial_bit_clock,
  // Result pin of the device.
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  // The bit clock idles high and stands still between frames.
  initial begin
    conversion_select_n = 1'b1;
    serial_bit_clock = 1'b1;
  end
  // One frame; a bit is taken just before each fall, unknown if not driven.
  task automatic frame(input int falls, output logic [15:0] word);
    word = 16'h0000;
    // Pins move by non-blocking assignment so a clock edge never races them.
    conversion_select_n <= 1'b0;
    #62.5;
    for (int k = 0; k < falls; k++) begin
      word[15-k] = serial_result_oe ? serial_result_out : 1'bx;
      serial_bit_clock <= 1'b0;
      #62.5;
      serial_bit_clock <= 1'b1;
      #62.5;
    end
    conversion_select_n <= 1'b1;
    #500;
  endtask
endmodule

// File: spmc_ctrl_bench.sv
// Self-checking bench for the converter mode-control block.
`timescale 1ns/100ps
module spmc_ctrl_bench;
  import spmc_pkg::*;
  logic                clk = 1'b0;
  logic                srst = 1'b1;
  logic                conversion_select_n, serial_bit_clock;
  logic                serial_result_out, serial_result_oe;
  logic [SAMPLE_W-1:0] conv_data = 12'h000;
  logic                conv_valid = 1'b0;
  logic                conv_ready, sample_hold, analog_power_en;
  logic                powered_up, mode_normal, result_dummy;
  int                  n_fail = 0;
  int                  comparisons = 0;
  // Words the buffer should hold, oldest first.
  logic [SAMPLE_W-1:0] q[$];
  spmc_ctrl spmc_ctrl_i (.clk(clk), .srst(srst), .conversion_select_n(conversion_select_n),
    .serial_bit_clock(serial_bit_clock), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .conv_data(conv_data), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .sample_hold(sample_hold), .analog_power_en(analog_power_en),
    .powered_up(powered_up), .mode_normal(mode_normal), .result_dummy(result_dummy));
  spmc_host spmc_host_i (.conversion_select_n(conversion_select_n),
    .serial_bit_clock(serial_bit_clock), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Offer one word and hold it until the buffer takes it; a bounded wait.
  task automatic push(input logic [SAMPLE_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    conv_data <= d;
    conv_valid <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (conv_ready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      summarize();
    end
    @(posedge clk);
    conv_valid <= 1'b0;
    q.push_back(d);
  endtask
  // Two words fill the buffer, which must then refuse more.
  task automatic s_fill;
    push(12'h9C3);
    push(12'h3A5);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("ready", conv_ready, 1'b0);
  endtask
  // Frames of many lengths from both modes; the last ones drain the buffer.
  task automatic s_frames;
    int f[9] = '{16, 16, 1, 2, 1, 10, 12, 9, 16};
    logic nm, dm;
    logic [15:0] w, e, m;
    nm = 1'b0;
    for (int i = 0; i < 9; i++) begin
      e = {3'b000, (q.size() > 0) ? q.pop_front() : 12'h000, 1'b0};
      m = 16'(16'hFFFF << (16 - f[i]));
      dm = !nm;
      @(posedge clk);
      spmc_host_i.frame(f[i], w);
      nm = (f[i] >= 10) || (f[i] < 2 && nm);
      check("word", w & m, e & m);
      check("mode", mode_normal, nm);
      check("power", analog_power_en, nm);
      check("powered", powered_up, nm);
      check("dummy", result_dummy, dm);
      check("oe", serial_result_oe, 1'b0);
      if (i < 5) push(12'(12'h5A3 + i * 37));
    end
  endtask
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    s_fill();
    s_frames();
    summarize();
  end
endmodule
